// ### src/hpc_host_port_control_bank.sv
//Contract
//- Hardware sets ready flag when value available.
//- Reading value clears flag; next after 160ms.
//- Reset restarts generation; flag after 160us.
//- Expanded bus select routes moves to ports.
//- Select clear routes moves to bytewide bus.
//- Loader cannot change the five control bits.
//- Reload enable forces 4kB partition, any mode.
//- Clearing reload restores prior memory configuration.
//- Vector select disables timer 1 interrupt.
//- Vector select sets only with port enabled.
//- Vector select clears on reset, port disable.
//- DMA enable with port active permits DMA.
//- DMA sets only with port; clears likewise.
//- Port enable turns on host slave protocol.
//- Bit 0 holds one program range bit.
//- Range bit clears only on special resets or loader writes of 0.
`timescale 1ns/1ps
module hpc_host_port_control_bank #(
    parameter int unsigned RESET_CYCLES = hpc_pkg::HPC_RST_CYCLES,
    parameter int unsigned READ_CYCLES  = hpc_pkg::HPC_RD_CYCLES
) (
    input  wire logic                          clock,
    input  wire logic                          rst,
    input  wire logic                          range_clear,
    input  wire logic [hpc_pkg::HPC_ADDR_W-1:0] paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          bootstrap_mode,
    input  wire logic                          timed_access_open,
    input  wire logic                          partition_mode_setting,
    input  wire logic                          timer1_irq_in,
    input  wire logic                          host_port_irq_in,
    output logic                               external_data_move_expanded,
    output logic                               partition_force_4k,
    output logic                               partition_mode_effective,
    output logic                               timer1_irq,
    output logic                               host_port_irq,
    output logic                               dma_permit,
    output logic                               host_port_active,
    output logic                               program_range_bit0
);
    import hpc_pkg::*;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        exbus;
        logic        reload;
        logic        ivs;
        logic        dma;
        logic        hpe;
        logic        range0;
        logic        xmove_exp;
        logic        part_mode;
        logic        t1_irq;
        logic        hp_irq;
        logic        dma_ok;
        logic        port_host;
    } hpc_state_t;

    hpc_state_t r;
    hpc_state_t next_r;

    logic       rng_ready;
    logic [7:0] rng_value;
    logic       setup;
    logic       done;
    logic       hit_ctrl;
    logic       hit_random;
    logic       ctrl_write;
    logic       random_read;
    logic       new_hpe;
    logic [7:0] ctrl_view;

    hpc_rng #(
        .RESET_CYCLES (RESET_CYCLES),
        .READ_CYCLES  (READ_CYCLES)
    ) hpc_rng_inst (
        .clock   (clock),
        .rst     (rst),
        .consume (random_read),
        .value   (rng_value),
        .ready   (rng_ready)
    );

    assign setup       = psel & ~penable;
    assign done        = psel & penable & r.pready;
    assign hit_ctrl    = (paddr == HPC_ADDR_CTRL);
    assign hit_random  = (paddr == HPC_ADDR_RANDOM);
    assign ctrl_write  = done & pwrite & hit_ctrl;
    assign random_read = done & ~pwrite & hit_random;

    // Bit 6 is not implemented and always reads as zero.
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[HPC_BIT_READY]  = rng_ready;
        ctrl_view[HPC_BIT_EXBUS]  = r.exbus;
        ctrl_view[HPC_BIT_RELOAD] = r.reload;
        ctrl_view[HPC_BIT_IVS]    = r.ivs;
        ctrl_view[HPC_BIT_DMA]    = r.dma;
        ctrl_view[HPC_BIT_HPE]    = r.hpe;
        ctrl_view[HPC_BIT_RANGE]  = r.range0;
    end

    // Read data and the answer are prepared in the setup cycle, so every
    // transfer completes in its first access cycle with no wait state.
    always_comb begin
        next_r = r;
        new_hpe = r.hpe;
        next_r.pready  = setup;
        next_r.pslverr = setup & ~hit_ctrl & ~hit_random;
        next_r.prdata  = 32'h0000_0000;
        if (setup & ~pwrite & hit_ctrl) begin
            next_r.prdata = {24'h00_0000, ctrl_view};
        end else if (setup & ~pwrite & hit_random) begin
            next_r.prdata = {24'h00_0000, rng_value};
        end

        if (ctrl_write) begin
            if (bootstrap_mode) begin
                next_r.range0 = pwdata[HPC_BIT_RANGE];
            end else begin
                new_hpe = pwdata[HPC_BIT_HPE];
                next_r.hpe   = new_hpe;
                next_r.exbus = pwdata[HPC_BIT_EXBUS];
                // Both gated bits need the port already enabled.
                next_r.ivs = pwdata[HPC_BIT_IVS] & r.hpe;
                next_r.dma = pwdata[HPC_BIT_DMA] & r.hpe;
                if (timed_access_open) begin
                    next_r.reload = pwdata[HPC_BIT_RELOAD];
                end
            end
        end
        if (!new_hpe) begin
            next_r.ivs = 1'b0;
            next_r.dma = 1'b0;
        end

        if (rst) begin
            next_r.pready  = 1'b0;
            next_r.pslverr = 1'b0;
            next_r.prdata  = 32'h0000_0000;
            next_r.exbus   = HPC_CTRL_RST;
            next_r.reload  = HPC_CTRL_RST;
            next_r.ivs     = HPC_CTRL_RST;
            next_r.dma     = HPC_CTRL_RST;
            next_r.hpe     = HPC_CTRL_RST;
        end
        // The range bit survives an ordinary reset on purpose.
        if (range_clear) begin
            next_r.range0 = HPC_CTRL_RST;
        end

        // Routing outputs follow the new register values in the same edge.
        next_r.xmove_exp = next_r.exbus;
        next_r.part_mode = next_r.reload ? 1'b0
                                         : partition_mode_setting;
        next_r.t1_irq    = timer1_irq_in & ~next_r.ivs;
        next_r.hp_irq    = host_port_irq_in & next_r.ivs;
        next_r.dma_ok    = next_r.dma & next_r.hpe;
        next_r.port_host = next_r.hpe;
    end

    always_ff @(posedge clock) begin
        r <= next_r;
    end

    assign prdata                      = r.prdata;
    assign pready                      = r.pready;
    assign pslverr                     = r.pslverr;
    assign external_data_move_expanded = r.xmove_exp;
    assign partition_force_4k          = r.reload;
    assign partition_mode_effective    = r.part_mode;
    assign timer1_irq                  = r.t1_irq;
    assign host_port_irq               = r.hp_irq;
    assign dma_permit                  = r.dma_ok;
    assign host_port_active            = r.port_host;
    assign program_range_bit0          = r.range0;

    logic [HPC_CNT_W-1:0] since_rst;

    always_ff @(posedge clock) begin
        if (rst) begin
            since_rst <= '0;
        end else if (since_rst != '1) begin
            since_rst <= since_rst + HPC_CNT_W'(1);
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    ready_early_a: assert property (
        since_rst < HPC_CNT_W'(RESET_CYCLES) |-> !rng_ready)
        else $error("Random ready flag set before the reset delay.");

    ready_late_a: assert property (
        since_rst == HPC_CNT_W'(RESET_CYCLES) |-> rng_ready)
        else $error("Random ready flag missing after the reset delay.");

    ready_clear_a: assert property (
        random_read |=> !rng_ready ##1 !rng_ready)
        else $error("Reading the random value left the flag set.");

    exbus_route_a: assert property (
        ctrl_write && !bootstrap_mode
        |=> external_data_move_expanded == $past(pwdata[HPC_BIT_EXBUS]))
        else $error("Data move routing does not follow the bus select.");

    boot_lock_a: assert property (
        ctrl_write && bootstrap_mode
        |=> $stable({r.exbus, r.reload, r.ivs, r.dma, r.hpe}))
        else $error("Loader write changed a protected control bit.");

    reload_part_a: assert property (
        partition_force_4k |-> !partition_mode_effective)
        else $error("Reload enable did not force the partition.");

    reload_restore_a: assert property (
        !next_r.reload ##1 !partition_force_4k
        |-> partition_mode_effective == $past(partition_mode_setting))
        else $error("Prior memory configuration not restored.");

    reload_timed_a: assert property (
        ctrl_write && !timed_access_open |=> $stable(partition_force_4k))
        else $error("Reload bit changed without timed access.");

    timer_mask_a: assert property (
        r.ivs |-> !timer1_irq && host_port_irq == $past(host_port_irq_in))
        else $error("Timer 1 interrupt not diverted to the host port.");

    ivs_gate_a: assert property (
        $rose(r.ivs) |-> $past(r.hpe) && r.hpe)
        else $error("Vector select set while the port was disabled.");

    dma_gate_a: assert property (
        dma_permit |-> r.dma && host_port_active && $past(r.hpe))
        else $error("DMA permitted without the host port enabled.");

    range_hold_a: assert property (
        ctrl_write && !bootstrap_mode && !range_clear
        |=> $stable(program_range_bit0))
        else $error("Range bit changed outside the loader.");

    port_release_a: assert property (
        $fell(r.hpe) |-> !host_port_active && !dma_permit && !r.ivs)
        else $error("Ports not released when the host port was disabled.");

    ready_hold_a: assert property (
        rng_ready && !random_read |=> rng_ready)
        else $error("Random ready flag dropped without a read.");

    ready_read_a: assert property (
        done && !pwrite && hit_ctrl
        |-> prdata[HPC_BIT_READY] == $past(rng_ready))
        else $error("Control read shows a stale random ready flag.");

    exbus_byte_a: assert property (
        ctrl_write && !bootstrap_mode && !pwdata[HPC_BIT_EXBUS]
        |=> !external_data_move_expanded)
        else $error("Data moves not sent to the bytewide bus.");

    reload_set_a: assert property (
        ctrl_write && !bootstrap_mode && timed_access_open
        |=> partition_force_4k == $past(pwdata[HPC_BIT_RELOAD]))
        else $error("Timed write did not update the reload enable.");

    reload_keep_a: assert property (
        $fell(partition_force_4k)
        |-> partition_mode_effective == $past(partition_mode_setting))
        else $error("Prior partition mode not resumed after reload.");

    irq_pass_a: assert property (
        !r.ivs |-> !host_port_irq && timer1_irq == $past(timer1_irq_in))
        else $error("Interrupts misrouted with vector select clear.");

    gated_clear_a: assert property (
        !r.hpe |-> !r.ivs && !r.dma)
        else $error("Gated bits set while the host port is disabled.");

    dma_permit_a: assert property (
        r.dma && r.hpe |-> dma_permit)
        else $error("DMA not permitted with the host port active.");

    dma_rise_a: assert property (
        $rose(r.dma) |-> $past(r.hpe))
        else $error("DMA enable set while the port was disabled.");

    host_enable_a: assert property (
        ctrl_write && !bootstrap_mode
        |=> host_port_active == $past(pwdata[HPC_BIT_HPE]))
        else $error("Host port mode does not follow its enable bit.");

    // The range bit has its own clear, so an ordinary reset must not touch
    // it; these two watch straight through reset on purpose.
    range_keep_a: assert property (
        disable iff (1'b0)
        rst && !range_clear && !ctrl_write |=> $stable(program_range_bit0))
        else $error("Ordinary reset disturbed the range bit.");

    range_clear_a: assert property (
        disable iff (1'b0) range_clear |=> !program_range_bit0)
        else $error("Range bit survived a range clear.");

    reset_zero_a: assert property (
        $past(rst) |-> {r.exbus, r.reload, r.ivs, r.dma, r.hpe} == 5'h00)
        else $error("Control bits not zero after reset.");

    spare_zero_a: assert property (
        done && !pwrite && hit_ctrl
        |-> !prdata[HPC_BIT_SPARE] && prdata[31:8] == 24'h00_0000)
        else $error("Unused control bits read as nonzero.");

    apb_answer_a: assert property (
        setup |=> pready)
        else $error("Bus transfer not answered in its access cycle.");

    pready_only_a: assert property (
        pready |-> $past(setup))
        else $error("Bus answer without a preceding setup cycle.");

    unmapped_err_a: assert property (
        done && !hit_ctrl && !hit_random
        |-> pslverr && prdata == 32'h0000_0000)
        else $error("Unmapped access not flagged as an error.");

    mapped_ok_a: assert property (
        done && (hit_ctrl || hit_random) |-> !pslverr)
        else $error("Mapped access flagged as an error.");

    ctrl_read_cov: cover property (
        done && !pwrite && hit_ctrl && prdata[HPC_BIT_HPE]);
    random_read_cov: cover property (random_read ##[1:20] ctrl_write);
    ivs_set_cov: cover property ($rose(r.ivs));
    release_cov: cover property ($fell(r.hpe) && $past(r.dma));
    ready_set_cov: cover property ($rose(rng_ready));

endmodule

// ### src/hpc_pkg.sv
package hpc_pkg;

    // Registers sit at word index times four on the bus.
    localparam int unsigned HPC_ADDR_W      = 12;
    localparam logic [9:0]  HPC_IDX_RANDOM  = 10'h0CF;
    localparam logic [9:0]  HPC_IDX_CTRL    = 10'h0D8;
    localparam logic [11:0] HPC_ADDR_RANDOM = {HPC_IDX_RANDOM, 2'h0};
    localparam logic [11:0] HPC_ADDR_CTRL   = {HPC_IDX_CTRL, 2'h0};

    localparam int unsigned HPC_BIT_READY  = 7;
    localparam int unsigned HPC_BIT_SPARE  = 6;
    localparam int unsigned HPC_BIT_EXBUS  = 5;
    localparam int unsigned HPC_BIT_RELOAD = 4;
    localparam int unsigned HPC_BIT_IVS    = 3;
    localparam int unsigned HPC_BIT_DMA    = 2;
    localparam int unsigned HPC_BIT_HPE    = 1;
    localparam int unsigned HPC_BIT_RANGE  = 0;

    localparam logic        HPC_CTRL_RST   = 1'h0;
    localparam logic [7:0]  HPC_LFSR_SEED  = 8'h01;
    localparam logic [7:0]  HPC_LFSR_TAPS  = 8'hB8;

    localparam int unsigned HPC_CLK_NS       = 10;
    localparam int unsigned HPC_RST_DELAY_NS = 160000;
    localparam int unsigned HPC_RD_DELAY_NS  = 160000000;
    localparam int unsigned HPC_RST_CYCLES   = HPC_RST_DELAY_NS / HPC_CLK_NS;
    localparam int unsigned HPC_RD_CYCLES    = HPC_RD_DELAY_NS / HPC_CLK_NS;
    localparam int unsigned HPC_CNT_W        = 24;

    typedef enum logic {
        HPC_RNG_WAIT  = 1'b0,
        HPC_RNG_READY = 1'b1
    } hpc_rng_state_t;

endpackage

// ### src/hpc_rng.sv
`timescale 1ns/1ps
module hpc_rng #(
    parameter int unsigned RESET_CYCLES = hpc_pkg::HPC_RST_CYCLES,
    parameter int unsigned READ_CYCLES  = hpc_pkg::HPC_RD_CYCLES
) (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       consume,
    output logic [7:0]      value,
    output logic            ready
);
    import hpc_pkg::*;

    typedef struct packed {
        hpc_rng_state_t        state;
        logic [HPC_CNT_W-1:0]  cnt;
        logic [7:0]            lfsr;
        logic [7:0]            value;
        logic                  ready;
    } hpc_rng_regs_t;

    hpc_rng_regs_t r;
    hpc_rng_regs_t next_r;

    // The shift register runs every cycle, so the value captured depends on
    // how long software took to read. The seed is fixed, which makes the
    // sequence after reset repeatable; this is not a true entropy source.
    always_comb begin
        next_r = r;
        next_r.lfsr = {r.lfsr[6:0], ^(r.lfsr & HPC_LFSR_TAPS)};
        if (r.cnt != '0) begin
            next_r.cnt = r.cnt - HPC_CNT_W'(1);
        end
        case (r.state)
            HPC_RNG_WAIT: begin
                if (r.cnt == '0) begin
                    next_r.value = r.lfsr;
                    next_r.ready = 1'b1;
                    next_r.state = HPC_RNG_READY;
                end
            end
            HPC_RNG_READY: begin
                if (consume) begin
                    next_r.ready = 1'b0;
                    next_r.cnt   = HPC_CNT_W'(READ_CYCLES - 1);
                    next_r.state = HPC_RNG_WAIT;
                end
            end
            default: begin
                next_r.state = HPC_RNG_WAIT;
            end
        endcase
        if (rst) begin
            next_r.state = HPC_RNG_WAIT;
            next_r.cnt   = HPC_CNT_W'(RESET_CYCLES - 1);
            next_r.lfsr  = HPC_LFSR_SEED;
            next_r.value = 8'h00;
            next_r.ready = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        r <= next_r;
    end

    assign value = r.value;
    assign ready = r.ready;

endmodule

// ### testbench/hpc_host_model.sv
`timescale 1ns/1ps
// Host processor on the slave port: it only signals while the port is live.
module hpc_host_model (
    input  wire logic clock,
    input  wire logic want,
    input  wire logic active,
    output logic      irq
);
    initial irq = 1'b0;
    always @(posedge clock) begin
        irq <= want & active;
    end
endmodule

// ### testbench/test_host_port_control_bank.sv
`timescale 1ns/1ps
module test_host_port_control_bank;
    import hpc_pkg::*;
    logic        clock, rst, range_clear, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, boot, timed, want, h_irq;
    logic        exp_bus, force4k, part_eff, t1_irq, hp_irq, dma_ok, hp_on;
    logic        range_bit, pm_set, t1_in;
    int          err_total, comparisons, cycles;

    hpc_host_port_control_bank #(.RESET_CYCLES(20), .READ_CYCLES(30))
        hpc_host_port_control_bank_inst (
        .clock(clock), .rst(rst), .range_clear(range_clear),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bootstrap_mode(boot),
        .timed_access_open(timed), .partition_mode_setting(pm_set),
        .timer1_irq_in(t1_in), .host_port_irq_in(h_irq),
        .external_data_move_expanded(exp_bus),
        .partition_force_4k(force4k), .partition_mode_effective(part_eff),
        .timer1_irq(t1_irq), .host_port_irq(hp_irq), .dma_permit(dma_ok),
        .host_port_active(hp_on), .program_range_bit0(range_bit));

    hpc_host_model hpc_host_model_inst (
        .clock(clock), .want(want), .active(hp_on), .irq(h_irq));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until pready is seen high at a rising edge.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_ctrl(input logic [7:0] exp);
        apb(1'b0, HPC_ADDR_CTRL, 32'h0);
        chk(rd, {24'h0, exp});
    endtask

    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask

    task automatic do_reset(input logic rc, input int n);
        @(posedge clock);
        rst <= 1'b1;
        range_clear <= rc;
        repeat (n) @(posedge clock);
        rst <= 1'b0;
        range_clear <= 1'b0;
    endtask

    task automatic t_rng();
        rd_ctrl(8'h00);
        repeat (25) @(posedge clock);
        rd_ctrl(8'h80);
        apb(1'b0, HPC_ADDR_RANDOM, 32'h0);
        chk({31'h0, err}, 32'h0);
        rd_ctrl(8'h00);
        repeat (35) @(posedge clock);
        rd_ctrl(8'h80);
    endtask

    task automatic t_unmapped();
        apb(1'b0, 12'h000, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b1, HPC_ADDR_RANDOM, 32'hFF);
        chk({31'h0, err}, 32'h0);
        rd_ctrl(8'h80);
    endtask

    // Port not yet on and the timed window shut: only 5 and 1 may stick.
    task automatic t_refuse();
        timed <= 1'b0;
        apb(1'b1, HPC_ADDR_CTRL, 32'hFF);
        settle();
        chk({31'h0, exp_bus}, 32'h1);
        chk({31'h0, hp_on}, 32'h1);
        chk({31'h0, dma_ok}, 32'h0);
        chk({31'h0, force4k}, 32'h0);
        rd_ctrl(8'hA2);
    endtask

    task automatic t_enable();
        timed <= 1'b1;
        want <= 1'b1;
        apb(1'b1, HPC_ADDR_CTRL, 32'hFF);
        settle();
        rd_ctrl(8'hBE);
        chk({31'h0, force4k}, 32'h1);
        chk({31'h0, part_eff}, 32'h0);
        chk({31'h0, dma_ok}, 32'h1);
        chk({31'h0, t1_irq}, 32'h0);
        chk({31'h0, hp_irq}, 32'h1);
        apb(1'b1, HPC_ADDR_CTRL, 32'h3C);
        @(posedge clock);
        #1;
        chk({31'h0, hp_on}, 32'h0);
        chk({31'h0, dma_ok}, 32'h0);
        rd_ctrl(8'hB0);
        apb(1'b1, HPC_ADDR_CTRL, 32'h00);
        settle();
        chk({31'h0, part_eff}, 32'h1);
        chk({31'h0, exp_bus}, 32'h0);
        chk({31'h0, t1_irq}, 32'h1);
        rd_ctrl(8'h80);
        pm_set <= 1'b0;
        t1_in <= 1'b0;
        settle();
        chk({31'h0, part_eff}, 32'h0);
        chk({31'h0, t1_irq}, 32'h0);
        @(posedge clock);
        timed <= 1'b0;
        want <= 1'b0;
        pm_set <= 1'b1;
        t1_in <= 1'b1;
    endtask

    task automatic t_boot();
        boot <= 1'b1;
        apb(1'b1, HPC_ADDR_CTRL, 32'h3F);
        settle();
        chk({31'h0, range_bit}, 32'h1);
        rd_ctrl(8'h81);
        boot <= 1'b0;
        apb(1'b1, HPC_ADDR_CTRL, 32'h00);
        rd_ctrl(8'h81);
        do_reset(1'b0, 2);
        rd_ctrl(8'h01);
        @(posedge clock);
        range_clear <= 1'b1;
        @(posedge clock);
        range_clear <= 1'b0;
        rd_ctrl(8'h00);
    endtask

    initial begin
        err_total = 0;
        comparisons = 0;
        cycles = 0;
        rst = 1'b1;
        range_clear = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        boot = 1'b0;
        timed = 1'b0;
        want = 1'b0;
        pm_set = 1'b1;
        t1_in = 1'b1;
        // Ordinary reset leaves the range bit alone, so clear it alongside reset.
        do_reset(1'b1, 12);
        t_rng();
        t_unmapped();
        t_refuse();
        t_enable();
        t_boot();
        close_out();
    end
endmodule
